// File: rfx_pkg.sv
// Constants and types shared by the return and flag execution block.
// Assumes a 10-bit instruction word and a 20 MHz instruction clock.
package rfx_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int RFX_PC_W = 13;
  localparam int RFX_SP_W = 3;
  localparam int RFX_ADDR_W = 8;
  localparam int RFX_DATA_W = 32;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [9:0] RFX_OP_RET_INT = 10'h046;
  localparam logic [9:0] RFX_OP_RTS = 10'h045;
  localparam logic [9:0] RFX_OP_CLR_UPPER = 10'h058;
  localparam logic [9:0] RFX_OP_TABLE = 10'h080;
  localparam logic [9:0] RFX_OP_TABLE_MASK = 10'h3C0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int RFX_RTS_CYCLES = 2;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0] RFX_ADDR_CTRL = 8'h00;
  localparam logic [7:0] RFX_ADDR_STATUS = 8'h04;
  localparam logic [7:0] RFX_ADDR_PC = 8'h08;
  localparam logic [7:0] RFX_ADDR_SP = 8'h0C;
  localparam logic [7:0] RFX_ADDR_TABLE = 8'h10;
  localparam int RFX_CTRL_UPPER_EN_BIT = 0;
  localparam int RFX_STAT_UPPER_EN_BIT = 0;
  localparam int RFX_STAT_SKIP_BIT = 1;
  localparam int RFX_STAT_BUSY_BIT = 2;
  localparam int RFX_STAT_CARRY_BIT = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic RFX_UPPER_EN_RESET = 1'b0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] ptr_x;
    logic [3:0] ptr_y;
    logic [1:0] ptr_z;
    logic carry_flag;
    logic skip;
    logic nop_mode;
    logic [3:0] reg_a;
    logic [3:0] reg_b;
  } rfx_cpu_state_type;

  localparam rfx_cpu_state_type RFX_STATE_RESET = '0;

  typedef enum logic {
    RFX_EXEC_IDLE,
    RFX_EXEC_RTS_WAIT
  } rfx_exec_state_type;

  function automatic logic rfx_is_table(input logic [9:0] word);
    return (word & RFX_OP_TABLE_MASK) == RFX_OP_TABLE;
  endfunction

endpackage

// File: rfx_stack.sv
// Return address stack with its stack pointer.
// Assumes push and pop are never asked for in the same cycle.
`timescale 1ns/1ns
module rfx_stack
  import rfx_pkg::*;
#(
  parameter int PC_W = RFX_PC_W,
  parameter int SP_W = RFX_SP_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Stack operations
  input wire logic push,
  input wire logic [PC_W-1:0] push_pc,
  input wire logic pop,
  // Top of stack
  output logic [PC_W-1:0] top_pc,
  output logic [SP_W-1:0] stack_pointer
);

  localparam int DEPTH = 1 << SP_W;

  logic [PC_W-1:0] return_stack [DEPTH];
  logic [SP_W-1:0] sp_reg;
  logic [SP_W-1:0] sp_next;

  always_comb begin
    sp_next = sp_reg;
    if (push) begin
      sp_next = sp_reg + SP_W'(1);
    end else if (pop) begin
      sp_next = sp_reg - SP_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sp_reg <= '0;
    end else begin
      sp_reg <= sp_next;
    end
  end

  // No reset on the array: entries are only read after a push
  always_ff @(posedge clk) begin
    if (push) begin
      return_stack[sp_next] <= push_pc;
    end
  end

  assign top_pc = return_stack[sp_reg];
  assign stack_pointer = sp_reg;

endmodule

// File: rfx_state_save.sv
// Holds the CPU state captured at interrupt entry.
// Assumes the entry strobe is one cycle long.
`timescale 1ns/1ns
module rfx_state_save
  import rfx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Capture
  input wire logic capture,
  input wire rfx_cpu_state_type live_state,
  // Saved copy
  output rfx_cpu_state_type saved_state
);

  rfx_cpu_state_type saved_reg;
  rfx_cpu_state_type saved_next;

  always_comb begin
    saved_next = capture ? live_state : saved_reg;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      saved_reg <= RFX_STATE_RESET;
    end else begin
      saved_reg <= saved_next;
    end
  end

  assign saved_state = saved_reg;

endmodule

// File: rfx_exec.sv
// Executes return-from-interrupt, return-with-skip, the clear of the
// table upper-bits flag and its effect on table lookup.
// Assumes instruction, ROM word and live state are synchronous to clk.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
module rfx_exec
  import rfx_pkg::*;
#(
  parameter int PC_W = RFX_PC_W,
  parameter int SP_W = RFX_SP_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Instruction stream
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic [9:0] rom_word,
  // Calls and interrupt entry
  input wire logic push_valid,
  input wire logic [PC_W-1:0] push_pc,
  input wire logic int_entry,
  input wire rfx_cpu_state_type live_state,
  // Register port
  input wire logic [RFX_ADDR_W-1:0] reg_addr,
  input wire logic [RFX_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [RFX_DATA_W-1:0] reg_rdata,
  // Results to the CPU
  output logic [PC_W-1:0] pc_reg,
  output logic pc_load_reg,
  output logic restore_valid_reg,
  output rfx_cpu_state_type restore_state_reg,
  output logic skip_reg,
  output logic busy_reg,
  output logic table_valid_reg,
  output logic [7:0] table_data_reg,
  output logic [1:0] d_upper_reg,
  output logic table_upper_bits_enable_flag
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic take;
  logic do_ret_int;
  logic do_rts;
  logic do_clr_upper;
  logic do_table;
  logic [PC_W-1:0] top_pc;
  logic [SP_W-1:0] stack_pointer;
  rfx_cpu_state_type saved_state;

  // A skipped instruction is dropped; nothing is accepted while busy
  assign take = instr_valid && !busy_reg && !skip_reg;
  assign do_ret_int = take && instr_word == RFX_OP_RET_INT;
  assign do_rts = take && instr_word == RFX_OP_RTS;
  assign do_clr_upper = take && instr_word == RFX_OP_CLR_UPPER;
  assign do_table = take && rfx_is_table(instr_word);

  // ----------------------------------------
  // Stack and saved state
  // ----------------------------------------
  rfx_stack #(
    .PC_W(PC_W),
    .SP_W(SP_W)
  ) u_stack (
    .clk(clk),
    .rstn(rstn),
    .push(push_valid),
    .push_pc(push_pc),
    .pop(do_ret_int || do_rts),
    .top_pc(top_pc),
    .stack_pointer(stack_pointer)
  );

  rfx_state_save u_save (
    .clk(clk),
    .rstn(rstn),
    .capture(int_entry),
    .live_state(live_state),
    .saved_state(saved_state)
  );

  // ----------------------------------------
  // Execution
  // ----------------------------------------
  rfx_exec_state_type exec_reg;
  rfx_exec_state_type exec_next;
  logic [PC_W-1:0] pc_next;
  logic pc_load_next;
  logic restore_valid_next;
  rfx_cpu_state_type restore_state_next;
  logic skip_next;
  logic busy_next;
  logic table_valid_next;
  logic [7:0] table_data_next;
  logic [1:0] d_upper_next;
  logic upper_en_reg;
  logic upper_en_next;

  always_comb begin
    exec_next = exec_reg;
    pc_next = pc_reg;
    pc_load_next = 1'b0;
    restore_valid_next = 1'b0;
    restore_state_next = restore_state_reg;
    skip_next = skip_reg;
    busy_next = 1'b0;
    table_valid_next = 1'b0;
    table_data_next = table_data_reg;
    d_upper_next = d_upper_reg;
    upper_en_next = upper_en_reg;
    if (instr_valid && skip_reg && !busy_reg) begin
      skip_next = 1'b0;
    end
    case (exec_reg)
      RFX_EXEC_IDLE: begin
        if (do_ret_int) begin
          pc_next = top_pc;
          pc_load_next = 1'b1;
          restore_valid_next = 1'b1;
          restore_state_next = saved_state;
          skip_next = saved_state.skip;
        end else if (do_rts) begin
          pc_next = top_pc;
          pc_load_next = 1'b1;
          busy_next = 1'b1;
          exec_next = RFX_EXEC_RTS_WAIT;
        end else if (do_clr_upper) begin
          upper_en_next = 1'b0;
        end else if (do_table) begin
          table_valid_next = 1'b1;
          table_data_next = rom_word[7:0];
          if (upper_en_reg) begin
            d_upper_next = rom_word[9:8];
          end
        end
      end
      RFX_EXEC_RTS_WAIT: begin
        // Second cycle of the return arms an unconditional skip
        skip_next = 1'b1;
        exec_next = RFX_EXEC_IDLE;
      end
      default: begin
        exec_next = RFX_EXEC_IDLE;
      end
    endcase
    // Software write lands after the instruction, so it wins a tie
    if (reg_wr && reg_addr == RFX_ADDR_CTRL) begin
      upper_en_next = reg_wdata[RFX_CTRL_UPPER_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      exec_reg <= RFX_EXEC_IDLE;
      pc_reg <= '0;
      pc_load_reg <= 1'b0;
      restore_valid_reg <= 1'b0;
      restore_state_reg <= RFX_STATE_RESET;
      skip_reg <= 1'b0;
      busy_reg <= 1'b0;
      table_valid_reg <= 1'b0;
      table_data_reg <= 8'h00;
      d_upper_reg <= 2'h0;
      upper_en_reg <= RFX_UPPER_EN_RESET;
    end else begin
      exec_reg <= exec_next;
      pc_reg <= pc_next;
      pc_load_reg <= pc_load_next;
      restore_valid_reg <= restore_valid_next;
      restore_state_reg <= restore_state_next;
      skip_reg <= skip_next;
      busy_reg <= busy_next;
      table_valid_reg <= table_valid_next;
      table_data_reg <= table_data_next;
      d_upper_reg <= d_upper_next;
      upper_en_reg <= upper_en_next;
    end
  end

  assign table_upper_bits_enable_flag = upper_en_reg;

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  logic [RFX_DATA_W-1:0] rdata_next;
  logic [RFX_DATA_W-1:0] rdata_reg;

  always_comb begin
    rdata_next = '0;
    if (reg_rd) begin
      case (reg_addr)
        RFX_ADDR_CTRL: rdata_next[RFX_CTRL_UPPER_EN_BIT] = upper_en_reg;
        RFX_ADDR_STATUS: begin
          rdata_next[RFX_STAT_UPPER_EN_BIT] = upper_en_reg;
          rdata_next[RFX_STAT_SKIP_BIT] = skip_reg;
          rdata_next[RFX_STAT_BUSY_BIT] = busy_reg;
          rdata_next[RFX_STAT_CARRY_BIT] = restore_state_reg.carry_flag;
        end
        RFX_ADDR_PC: rdata_next[PC_W-1:0] = pc_reg;
        RFX_ADDR_SP: rdata_next[SP_W-1:0] = stack_pointer;
        RFX_ADDR_TABLE: rdata_next[9:0] = {d_upper_reg, table_data_reg};
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_rts_issue;
    do_rts;
  endsequence

  sequence s_rts_tail;
    busy_reg ##1 skip_reg;
  endsequence

  a_ret_int_restore: assert property (
    @(posedge clk) disable iff (!rstn)
    do_ret_int |=> restore_valid_reg && restore_state_reg == $past(saved_state))
    else $error("return from interrupt did not restore saved state");

  a_ret_int_pop: assert property (
    @(posedge clk) disable iff (!rstn)
    do_ret_int |=> pc_reg == $past(top_pc) && stack_pointer == $past(stack_pointer) - SP_W'(1) && !busy_reg)
    else $error("return from interrupt pc or pointer wrong");

  a_rts_pc_pop: assert property (
    @(posedge clk) disable iff (!rstn)
    do_rts |=> pc_reg == $past(top_pc) && stack_pointer == $past(stack_pointer) - 1'b1)
    else $error("return with skip pc or pointer wrong");

  a_rts_two_cycle: assert property (
    @(posedge clk) disable iff (!rstn)
    s_rts_issue |=> s_rts_tail)
    else $error("return with skip did not take two cycles then skip");

  a_skip_drops_instr: assert property (
    @(posedge clk) disable iff (!rstn)
    instr_valid && skip_reg && !busy_reg |-> !take ##1 !skip_reg)
    else $error("skipped instruction was executed");

  a_clear_upper_flag: assert property (
    @(posedge clk) disable iff (!rstn)
    do_clr_upper && !reg_wr |=> !table_upper_bits_enable_flag && !skip_reg && $stable(restore_state_reg.carry_flag))
    else $error("clear table bits did not clear flag alone");

  a_table_no_upper: assert property (
    @(posedge clk) disable iff (!rstn)
    do_table && !upper_en_reg |=> table_valid_reg && $stable(d_upper_reg))
    else $error("upper table bits written while flag clear");

  a_table_upper: assert property (
    @(posedge clk) disable iff (!rstn)
    do_table && upper_en_reg |=> d_upper_reg == $past(rom_word[9:8]))
    else $error("upper table bits not written while flag set");

endmodule

// File: test_rfx_exec.sv
// Self-checking bench for the return and flag execution block.
// Assumes rfx_pkg is compiled first; the bench drives every port of rfx_exec.
`timescale 1ns/1ns
module test_rfx_exec;
  import rfx_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic instr_valid = 1'h0;
  logic [9:0] instr_word = 10'h000;
  logic [9:0] rom_word = 10'h000;
  logic push_valid = 1'h0;
  logic [RFX_PC_W-1:0] push_pc = '0;
  logic int_entry = 1'h0;
  rfx_cpu_state_type live_state = RFX_STATE_RESET;
  logic [RFX_ADDR_W-1:0] reg_addr = '0;
  logic [RFX_DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [RFX_DATA_W-1:0] reg_rdata;
  logic [RFX_PC_W-1:0] pc_reg;
  logic pc_load_reg, restore_valid_reg, skip_reg, busy_reg, table_valid_reg, flag;
  rfx_cpu_state_type restore_state_reg;
  logic [7:0] table_data_reg;
  logic [1:0] d_upper_reg;
  int checks = 0;
  int mismatches = 0;
  int cycles = 0;
  logic [2:0] sp_model = 3'h0;

  rfx_exec u_dut (
    .clk(clk), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
    .rom_word(rom_word), .push_valid(push_valid), .push_pc(push_pc), .int_entry(int_entry),
    .live_state(live_state), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pc_reg(pc_reg), .pc_load_reg(pc_load_reg),
    .restore_valid_reg(restore_valid_reg), .restore_state_reg(restore_state_reg),
    .skip_reg(skip_reg), .busy_reg(busy_reg), .table_valid_reg(table_valid_reg),
    .table_data_reg(table_data_reg), .d_upper_reg(d_upper_reg),
    .table_upper_bits_enable_flag(flag)
  );

  always #25 clk = ~clk;

  // Cuts a hang short; the full run needs about six hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Expectations
  // ----------------------------------------
  function automatic logic [1:0] exp_upper(input logic [1:0] old, input logic [9:0] rom, input logic en);
    return en ? rom[9:8] : old;
  endfunction

  function automatic logic [31:0] exp_status(input logic en, input logic skip, input logic carry);
    return {28'h0000000, carry, 1'h0, skip, en};
  endfunction

  // ----------------------------------------
  // Drivers and compare
  // ----------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Results are sampled just after the edge that registers them
  task automatic instr(input logic [9:0] w, input logic [9:0] r);
    @(posedge clk);
    instr_valid <= 1'h1;
    instr_word <= w;
    rom_word <= r;
    @(posedge clk);
    instr_valid <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  task automatic push(input logic [RFX_PC_W-1:0] p);
    @(posedge clk);
    push_valid <= 1'h1;
    push_pc <= p;
    @(posedge clk);
    push_valid <= 1'h0;
    sp_model++;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [31:0] rnd, d;
    logic [RFX_PC_W-1:0] pa, pb;
    rfx_cpu_state_type st;
    logic [9:0] r1, r2;
    logic [1:0] up;
    void'($urandom(32'h98A36800));
    up = 2'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'h1;
    #1;
    chk("pc after reset", pc_reg, 32'h0);
    chk("flag after reset", flag, 32'h0);
    rd(RFX_ADDR_CTRL, d);
    chk("ctrl reset", d, 32'h0);
    rd(8'h20, d);
    chk("unmapped read", d, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 20; i++) begin
      rnd = $urandom;
      pa = rnd[12:0];
      rnd = $urandom;
      pb = rnd[12:0];
      rnd = $urandom;
      st = rnd[20:0];
      push(pa);
      push(pb);
      @(posedge clk);
      live_state <= st;
      int_entry <= 1'h1;
      @(posedge clk);
      int_entry <= 1'h0;
      live_state <= ~st;
      instr(RFX_OP_RET_INT, 10'h000);
      sp_model--;
      chk("int return pc", pc_reg, pb);
      chk("int return load", pc_load_reg, 32'h1);
      chk("int return restore pulse", restore_valid_reg, 32'h1);
      chk("int return state", restore_state_reg, st);
      chk("int return skip", skip_reg, st.skip);
      if (st.skip) begin
        instr(10'h000, 10'h000);
      end
      rd(RFX_ADDR_SP, d);
      chk("sp after int return", d, sp_model);
      wr(RFX_ADDR_CTRL, 32'h1);
      #1;
      chk("flag set", flag, 32'h1);
      instr(RFX_OP_RTS, 10'h000);
      sp_model--;
      chk("rts pc", pc_reg, pa);
      chk("rts load", pc_load_reg, 32'h1);
      chk("rts busy", busy_reg, 32'h1);
      @(posedge clk);
      #1;
      chk("rts skip", skip_reg, 32'h1);
      chk("rts busy end", busy_reg, 32'h0);
      instr(RFX_OP_CLR_UPPER, 10'h000);
      chk("skipped clear", flag, 32'h1);
      chk("skip cleared", skip_reg, 32'h0);
      rd(RFX_ADDR_SP, d);
      chk("sp after rts", d, sp_model);
      rnd = $urandom;
      r1 = rnd[9:0];
      instr(RFX_OP_TABLE | {4'h0, rnd[15:10]}, r1);
      up = exp_upper(up, r1, 1'h1);
      chk("table pulse", table_valid_reg, 32'h1);
      chk("table upper on", d_upper_reg, up);
      instr(RFX_OP_CLR_UPPER, 10'h000);
      chk("flag cleared", flag, 32'h0);
      chk("no skip", skip_reg, 32'h0);
      rd(RFX_ADDR_STATUS, d);
      chk("status carry kept", d, exp_status(1'h0, 1'h0, st.carry_flag));
      rnd = $urandom;
      r2 = rnd[9:0];
      instr(RFX_OP_TABLE | {4'h0, rnd[15:10]}, r2);
      up = exp_upper(up, r2, 1'h0);
      chk("table data", table_data_reg, r2[7:0]);
      chk("table upper off", d_upper_reg, up);
      rd(RFX_ADDR_TABLE, d);
      chk("table reg", d, {up, r2[7:0]});
      $display("test round %0d done", i);
    end
    // A write to a read-only place must leave it untouched
    wr(RFX_ADDR_PC, 32'h00001FFF);
    rd(RFX_ADDR_PC, d);
    chk("pc read only", d, pa);
    $display("test register port done");
    report_and_stop();
  end
endmodule
